// file: verilog/tcp_timer_top.sv
// 16-bit down-counting timer/counter/pwm with apb registers
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module tcp_timer_top (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tcp_pkg::AW-1:0]     paddr,
    input  wire logic [tcp_pkg::DW-1:0]     pwdata,
    output var  logic [tcp_pkg::DW-1:0]     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // routed inputs, synchronous to clock
    input  wire logic [tcp_pkg::NSRC-1:1]   tickSrc,
    input  wire logic                       timerResetIn,
    input  wire logic                       captureIn,
    input  wire logic                       enableIn,
    input  wire logic                       killIn,
    // outputs
    output logic                            cmpOut,
    output logic                            tcOut,
    output var  logic                       irq
);

    // ========================================================
    // declarations
    logic [tcp_pkg::CTRL_W-1:0] ctrlReg;
    logic [tcp_pkg::CNT_W-1:0]  periodReg;
    logic [tcp_pkg::CNT_W-1:0]  compareReg;
    logic [tcp_pkg::CNT_W-1:0]  countReg;
    logic [tcp_pkg::CNT_W-1:0]  captureReg;
    logic [tcp_pkg::DB_W-1:0]   deadReg;
    logic [tcp_pkg::INT_W-1:0]  intStatReg;
    logic [tcp_pkg::INT_W-1:0]  intMaskReg;
    logic [tcp_pkg::INT_W-1:0]  evBits;
    logic [tcp_pkg::INT_W-1:0]  clrBits;
    logic [tcp_pkg::NSRC-1:1]   srcPrev_reg;
    logic [tcp_pkg::NSRC-1:0]   srcEdge;
    logic [tcp_pkg::DW-1:0]     rdNext;
    logic [1:0]                 clkSel;
    tcp_pkg::tcp_mode_t         modeNow;
    tcp_pkg::tcp_cmp_t          relNow;
    logic setupPh;
    logic accessPh;
    logic wrEn;
    logic addrHit;
    logic startPulse;
    logic tick;
    logic modeGate;
    logic countEn;
    logic tcEvent;
    logic doneReg;
    logic tcLvlReg;
    logic capPrev_reg;
    logic capEvent;
    logic cmpNow;
    logic cmpPrev_reg;
    logic cmpEvent;
    logic dbTrue;
    logic dbCompl;

    // ========================================================
    // apb decode; zero wait states
    assign setupPh  = psel && !penable;
    assign accessPh = psel && penable;
    assign wrEn     = accessPh && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = accessPh && !addrHit;

    // read mux and address hit
    always_comb
    begin
        rdNext  = tcp_pkg::RD_ZERO;
        addrHit = 1'b1;
        case (paddr)
            tcp_pkg::OFS_CTRL:     rdNext = 32'(ctrlReg);
            tcp_pkg::OFS_PERIOD:   rdNext = 32'(periodReg);
            tcp_pkg::OFS_COMPARE:  rdNext = 32'(compareReg);
            tcp_pkg::OFS_COUNT:    rdNext = 32'(countReg);
            tcp_pkg::OFS_CAPTURE:  rdNext = 32'(captureReg);
            tcp_pkg::OFS_DEADBAND: rdNext = 32'(deadReg);
            tcp_pkg::OFS_INTSTAT:  rdNext = 32'(intStatReg);
            tcp_pkg::OFS_INTMASK:  rdNext = 32'(intMaskReg);
            default:               addrHit = 1'b0;
        endcase
    end

    // read data snapshotted in the setup cycle, so a read never
    // touches the counter itself
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            prdata <= tcp_pkg::RD_ZERO;
        else if (setupPh && !pwrite)
            prdata <= rdNext;
    end

    // ========================================================
    // writable registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrlReg    <= tcp_pkg::CTRL_RST;
            periodReg  <= tcp_pkg::PERIOD_RST;
            compareReg <= tcp_pkg::COMPARE_RST;
            deadReg    <= tcp_pkg::DB_ZERO;
            intMaskReg <= tcp_pkg::INT_RST;
        end
        else if (wrEn)
        begin
            case (paddr)
                tcp_pkg::OFS_CTRL:
                    ctrlReg <= pwdata[tcp_pkg::CTRL_W-1:0];
                tcp_pkg::OFS_PERIOD:
                    periodReg <= pwdata[tcp_pkg::CNT_W-1:0];
                tcp_pkg::OFS_COMPARE:
                    compareReg <= pwdata[tcp_pkg::CNT_W-1:0];
                tcp_pkg::OFS_DEADBAND:
                    deadReg <= pwdata[tcp_pkg::DB_W-1:0];
                tcp_pkg::OFS_INTMASK:
                    intMaskReg <= pwdata[tcp_pkg::INT_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // start: enable bit rises, or is rewritten after a one shot ended
    assign startPulse = wrEn && (paddr == tcp_pkg::OFS_CTRL) &&
                        pwdata[tcp_pkg::CTL_EN] &&
                        (!ctrlReg[tcp_pkg::CTL_EN] || doneReg);

    // ========================================================
    // clock source selection; source 0 is every system clock
    assign clkSel     = ctrlReg[tcp_pkg::CTL_CLK +: 2];
    assign srcEdge[0] = 1'b1;

    generate
        for (genvar i = 1; i < tcp_pkg::NSRC; i++)
        begin : g_src
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    srcPrev_reg[i] <= 1'b0;
                else
                    srcPrev_reg[i] <= tickSrc[i];
            end
            assign srcEdge[i] = tickSrc[i] && !srcPrev_reg[i];
        end
    endgenerate

    assign tick = srcEdge[clkSel];

    // ========================================================
    // mode decode; code 11 is illegal and runs as free
    assign modeNow = tcp_pkg::tcp_mode_t'(ctrlReg[tcp_pkg::CTL_MODE +: 2]);

    always_comb
    begin
        unique case (modeNow)
            tcp_pkg::MODE_FREE:    modeGate = 1'b1;
            tcp_pkg::MODE_ONESHOT: modeGate = !doneReg;
            tcp_pkg::MODE_ENCTL:   modeGate = enableIn;
            default:               modeGate = 1'b1;
        endcase
    end

    assign countEn = ctrlReg[tcp_pkg::CTL_EN] && tick && modeGate;
    assign tcEvent = countEn && (countReg == tcp_pkg::CNT_ZERO);

    // ========================================================
    // down counter with period reload
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            countReg <= tcp_pkg::PERIOD_RST;
        else if (startPulse || timerResetIn)
            countReg <= periodReg;
        else if (tcEvent)
            countReg <= periodReg;
        else if (countEn)
            countReg <= countReg - tcp_pkg::CNT_ONE;
    end

    // one shot ends at terminal count, cleared only by a start
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            doneReg <= 1'b0;
        else if (startPulse)
            doneReg <= 1'b0;
        else if (tcEvent && (modeNow == tcp_pkg::MODE_ONESHOT))
            doneReg <= 1'b1;
    end

    // terminal count pulse, one system clock wide
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            tcLvlReg <= 1'b0;
        else
            tcLvlReg <= tcEvent;
    end

    // ========================================================
    // capture on rising edge of the capture input
    assign capEvent = captureIn && !capPrev_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            capPrev_reg <= 1'b0;
            captureReg  <= tcp_pkg::CNT_ZERO;
        end
        else
        begin
            capPrev_reg <= captureIn;
            if (capEvent)
                captureReg <= countReg;
        end
    end

    // ========================================================
    // comparator; undefined relation codes never compare true
    assign relNow = tcp_pkg::tcp_cmp_t'(ctrlReg[tcp_pkg::CTL_CMP +: 3]);

    always_comb
    begin
        unique case (relNow)
            tcp_pkg::cmp_less:
                cmpNow = countReg < compareReg;
            tcp_pkg::cmp_less_or_equal:
                cmpNow = countReg <= compareReg;
            tcp_pkg::cmp_equal:
                cmpNow = countReg == compareReg;
            tcp_pkg::cmp_greater_or_equal:
                cmpNow = countReg >= compareReg;
            tcp_pkg::cmp_greater:
                cmpNow = countReg > compareReg;
            default:
                cmpNow = 1'b0;
        endcase
    end

    // compare event on the rising edge of compare true
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cmpPrev_reg <= 1'b0;
        else
            cmpPrev_reg <= cmpNow;
    end

    assign cmpEvent = cmpNow && !cmpPrev_reg;

    // ========================================================
    // pwm pair with dead band and kill
    tcp_deadband u_dead (
        .clock    (clock),
        .rst_n    (rst_n),
        .tick     (tick),
        .level    (cmpNow),
        .kill     (killIn),
        .dbLen    (deadReg),
        .trueOut  (dbTrue),
        .complOut (dbCompl)
    );

    // static select between two flops
    assign cmpOut = dbTrue;
    assign tcOut  = ctrlReg[tcp_pkg::CTL_TCCMP] ? dbCompl : tcLvlReg;

    // ========================================================
    // interrupt status, write one to clear; set wins over clear
    assign evBits = {capEvent, cmpEvent, tcEvent};
    assign clrBits = (wrEn && (paddr == tcp_pkg::OFS_INTSTAT)) ?
                     pwdata[tcp_pkg::INT_W-1:0] : tcp_pkg::INT_RST;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            intStatReg <= tcp_pkg::INT_RST;
        else
            intStatReg <= (intStatReg & ~clrBits) | evBits;
    end

    // mask selects which sources reach the request line
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(intStatReg & intMaskReg);
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_count_down_step: assert property (
        countEn && !tcEvent && !startPulse && !timerResetIn
        |=> countReg == $past(countReg) - tcp_pkg::CNT_ONE)
        else $error("counter did not step down by one");

    a_clock_source: assert property (
        !srcEdge[clkSel] |-> !countEn)
        else $error("counted without a selected clock edge");

    a_reload_start: assert property (
        startPulse || timerResetIn
        |=> countReg == $past(periodReg))
        else $error("no period reload on start or reset");

    a_tc_reload: assert property (
        tcEvent && !startPulse && !timerResetIn
        |=> countReg == $past(periodReg) && tcLvlReg)
        else $error("terminal count not flagged or not reloaded");

    a_irq_tc_sets: assert property (
        tcEvent && intMaskReg[tcp_pkg::INT_TC] && !wrEn
        |=> intStatReg[tcp_pkg::INT_TC] ##1 irq)
        else $error("terminal count did not raise the interrupt");

    a_oneshot_stop: assert property (
        tcEvent && modeNow == tcp_pkg::MODE_ONESHOT && !startPulse
        |=> doneReg && !countEn)
        else $error("one shot kept running past its period");

    a_enable_hold: assert property (
        modeNow == tcp_pkg::MODE_ENCTL && !enableIn &&
        !startPulse && !timerResetIn |=> $stable(countReg))
        else $error("counter moved while enable input low");

    a_read_no_touch: assert property (
        accessPh && !pwrite && !countEn && !startPulse &&
        !timerResetIn |=> $stable(countReg))
        else $error("a read disturbed the counter");

    a_capture_value: assert property (
        capEvent |=> captureReg == $past(countReg))
        else $error("capture register missed the count");

    a_kill_outputs: assert property (
        killIn |=> !cmpOut && !dbCompl)
        else $error("outputs active while killed");

    a_pair_exclusive: assert property (
        !(dbTrue && dbCompl))
        else $error("true and complement outputs overlap");

    a_mode_free: assert property (
        ctrlReg[tcp_pkg::CTL_EN] && tick &&
        modeNow == tcp_pkg::MODE_FREE |-> countEn)
        else $error("free running mode skipped a tick");

    c_oneshot_end: cover property (
        modeNow == tcp_pkg::MODE_ONESHOT && tcEvent ##1 doneReg);
    c_capture_run: cover property (capEvent && countEn);
    c_dead_gap: cover property (
        dbTrue ##1 (!dbTrue && !dbCompl) [*2] ##1 dbCompl);
    c_irq_raised: cover property ($rose(irq));

endmodule

`default_nettype wire

// file: verilog/tcp_pkg.sv
// shared constants and types of the 16-bit timer/counter/pwm unit
package tcp_pkg;

    // ========================================================
    // widths
    localparam int CNT_W  = 16;
    localparam int DB_W   = 8;
    localparam int NSRC   = 4;
    localparam int AW     = 8;
    localparam int DW     = 32;
    localparam int CTRL_W = 9;
    localparam int INT_W  = 3;

    // ========================================================
    // register byte offsets
    localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
    localparam logic [AW-1:0] OFS_PERIOD   = 8'h04;
    localparam logic [AW-1:0] OFS_COMPARE  = 8'h08;
    localparam logic [AW-1:0] OFS_COUNT    = 8'h0c;
    localparam logic [AW-1:0] OFS_CAPTURE  = 8'h10;
    localparam logic [AW-1:0] OFS_DEADBAND = 8'h14;
    localparam logic [AW-1:0] OFS_INTSTAT  = 8'h18;
    localparam logic [AW-1:0] OFS_INTMASK  = 8'h1c;

    // ========================================================
    // control fields and interrupt bits
    localparam int CTL_EN    = 0;
    localparam int CTL_MODE  = 1;
    localparam int CTL_CMP   = 3;
    localparam int CTL_CLK   = 6;
    localparam int CTL_TCCMP = 8;
    localparam int INT_TC    = 0;
    localparam int INT_CMP   = 1;
    localparam int INT_CAP   = 2;

    // ========================================================
    // reset values and count constants
    localparam logic [CTRL_W-1:0] CTRL_RST    = 9'h000;
    localparam logic [CNT_W-1:0]  PERIOD_RST  = 16'hffff;
    localparam logic [CNT_W-1:0]  COMPARE_RST = 16'h8000;
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 16'h0001;
    localparam logic [DB_W-1:0]   DB_ZERO     = 8'h00;
    localparam logic [DB_W-1:0]   DB_ONE      = 8'h01;
    localparam logic [INT_W-1:0]  INT_RST     = 3'h0;
    localparam logic [DW-1:0]     RD_ZERO     = 32'h0000_0000;

    // ========================================================
    // operating modes and comparator relations
    typedef enum logic [1:0] {
        MODE_FREE    = 2'b00,
        MODE_ONESHOT = 2'b01,
        MODE_ENCTL   = 2'b10
    } tcp_mode_t;

    typedef enum logic [2:0] {
        cmp_less             = 3'b000,
        cmp_less_or_equal    = 3'b001,
        cmp_equal            = 3'b010,
        cmp_greater_or_equal = 3'b011,
        cmp_greater          = 3'b100
    } tcp_cmp_t;

endpackage

// file: verilog/tcp_deadband.sv
// dead-band generator for the true/complementary pwm pair
`timescale 1ns/1ps
`default_nettype none

module tcp_deadband (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // control
    input  wire logic                    tick,
    input  wire logic                    level,
    input  wire logic                    kill,
    input  wire logic [tcp_pkg::DB_W-1:0] dbLen,
    // outputs
    output var  logic                    trueOut,
    output var  logic                    complOut
);

    logic                     lastLevel_reg;
    logic [tcp_pkg::DB_W-1:0] dbCnt_reg;
    logic                     settled;

    // a level is only shown once it is stable and the gap has run out
    assign settled = (level == lastLevel_reg) &&
                     (dbCnt_reg == tcp_pkg::DB_ZERO);

    // ========================================================
    // gap counter, counted in counter ticks
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lastLevel_reg <= 1'b0;
            dbCnt_reg     <= tcp_pkg::DB_ZERO;
        end
        else if (level != lastLevel_reg)
        begin
            lastLevel_reg <= level;
            dbCnt_reg     <= dbLen;
        end
        else if (tick && (dbCnt_reg != tcp_pkg::DB_ZERO))
        begin
            dbCnt_reg <= dbCnt_reg - tcp_pkg::DB_ONE;
        end
    end

    // ========================================================
    // both low during the gap and while killed
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            trueOut  <= 1'b0;
            complOut <= 1'b0;
        end
        else
        begin
            trueOut  <= !kill && settled && level;
            complOut <= !kill && settled && !level;
        end
    end

    // ========================================================
    // a fresh level change must blank both outputs at once
    a_gap_both_low: assert property (
        @(posedge clock) disable iff (!rst_n)
        level != lastLevel_reg |=> !trueOut && !complOut)
        else $error("output active at a level change");

endmodule

`default_nettype wire

// file: verif/tcp_route_model.sv
// routing-side model that drives the timer's routed inputs
`timescale 1ns/1ps
`default_nettype none

module tcp_route_model (
    // clock
    input  wire logic       clock,
    // routed lines, changed only just after a rising edge
    output var  logic [3:1] tickSrc,
    output var  logic       timerResetIn,
    output var  logic       captureIn,
    output var  logic       enableIn,
    output var  logic       killIn
);
    // ========================================================
    // line drivers
    // all lines quiet at time zero
    initial {tickSrc, timerResetIn, captureIn, enableIn, killIn} = 7'h00;

    // n rising edges on source s, two clocks apart
    task automatic ticks(input int s, input int n);
        repeat (n)
        begin
            @(posedge clock) tickSrc[s] <= 1'b1;
            @(posedge clock) tickSrc[s] <= 1'b0;
        end
    endtask

    // one-clock pulse: capture if cap, else reload
    task automatic pulse(input bit cap);
        @(posedge clock) {captureIn, timerResetIn} <= {cap, !cap};
        @(posedge clock) {captureIn, timerResetIn} <= 2'b00;
    endtask

    // enable seen high at exactly n edges
    task automatic hold(input int n);
        @(posedge clock) enableIn <= 1'b1;
        repeat (n) @(posedge clock);
        enableIn <= 1'b0;
    endtask

    // kill level, taken at the next edge
    task automatic kill(input bit v);
        @(posedge clock) killIn <= v;
    endtask
endmodule
`default_nettype wire

// file: verif/tcp_timer_top_tb.sv
// self-checking bench of the timer/counter/pwm unit
`timescale 1ns/1ps
`default_nettype none

module tcp_timer_top_tb;
    // ========================================================
    // signals
    logic        clock, rst_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic [3:1]  tickSrc;
    logic        timerResetIn, captureIn, enableIn, killIn;
    logic        cmpOut, tcOut, irq;
    int          mismatches, checks, n, k;
    logic [15:0] per;
    typedef struct {string s; logic [31:0] d, m; logic e;} tcp_note_t;
    tcp_note_t   notes[$];
    tcp_note_t   got;

    tcp_timer_top u_tcp_timer_top (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tickSrc(tickSrc), .timerResetIn(timerResetIn),
        .captureIn(captureIn), .enableIn(enableIn), .killIn(killIn),
        .cmpOut(cmpOut), .tcOut(tcOut), .irq(irq)
    );
    tcp_route_model u_tcp_route_model (
        .clock(clock), .tickSrc(tickSrc), .timerResetIn(timerResetIn),
        .captureIn(captureIn), .enableIn(enableIn), .killIn(killIn)
    );

    // 20 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ========================================================
    // checking and bus tasks
    task automatic check(input string s, input logic [31:0] v,
                         input logic [31:0] x);
        checks++;
        if (v !== x)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", s, x, v);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // left in access phase so a setup may follow; idle releases it
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    // the note is queued before the read goes out
    task automatic rd(input string s, input logic [7:0] a,
                      input logic [31:0] x, input logic [31:0] m = '1,
                      input logic e = 1'b0);
        notes.push_back('{s, x, m, e});
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic idle(input int c);
        {psel, penable} <= 2'b00;
        repeat (c) @(posedge clock);
    endtask

    // pins looked at mid-cycle, where they have settled
    task automatic pins(input logic c, input logic t, input logic i);
        @(negedge clock);
        check("cmpOut", {31'h0, cmpOut}, {31'h0, c});
        check("tcOut", {31'h0, tcOut}, {31'h0, t});
        check("irq", {31'h0, irq}, {31'h0, i});
        @(posedge clock);
    endtask

    // read answers matched against the oldest note
    always @(posedge clock)
        if (psel & penable & pready & !pwrite & (notes.size() > 0))
        begin
            got = notes.pop_front();
            check(got.s, prdata & got.m, got.d);
            check("pslverr", {31'h0, pslverr}, {31'h0, got.e});
        end

    // run needs about 300 clocks, so a hang is cut off well after
    initial
    begin
        repeat (5000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    // ========================================================
    // tests
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        checks = 0;
        k = $urandom(39863);
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        // reset values, a read-only count and an unmapped hole
        rd("ctrl", tcp_pkg::OFS_CTRL, 32'h0);
        rd("period", tcp_pkg::OFS_PERIOD, 32'hffff);
        rd("compare", tcp_pkg::OFS_COMPARE, 32'h8000);
        rd("deadband", tcp_pkg::OFS_DEADBAND, 32'h0);
        rd("intmask", tcp_pkg::OFS_INTMASK, 32'h0);
        wr(tcp_pkg::OFS_COUNT, 32'h5);
        rd("count", tcp_pkg::OFS_COUNT, 32'hffff);
        rd("hole", 8'h20, 32'h0, '1, 1'b1);
        idle(1);
        $display("test reset done");
        // free run: back-to-back reads see the count move by two
        wr(tcp_pkg::OFS_PERIOD, 32'h1000);
        wr(tcp_pkg::OFS_CTRL, 32'h1);
        rd("count", tcp_pkg::OFS_COUNT, 32'h1000);
        rd("count", tcp_pkg::OFS_COUNT, 32'h0ffe);
        idle(4);
        pins(1'b1, 1'b0, 1'b0);
        u_tcp_route_model.kill(1'b1);
        idle(3);
        pins(1'b0, 1'b0, 1'b0);
        u_tcp_route_model.kill(1'b0);
        u_tcp_route_model.pulse(1'b0);
        rd("count", tcp_pkg::OFS_COUNT, 32'h1000);
        idle(1);
        $display("test free run done");
        // relation flipped: both low over the dead band, then complement
        wr(tcp_pkg::OFS_DEADBAND, 32'h4);
        wr(tcp_pkg::OFS_CTRL, 32'h121);
        idle(2);
        repeat (2) pins(1'b0, 1'b0, 1'b0);
        idle(6);
        pins(1'b0, 1'b1, 1'b0);
        $display("test dead band done");
        // enable-controlled count, every relation, capture
        per = 16'h0100 + 16'($urandom_range(16'h7fff));
        n = $urandom_range(8, 1);
        wr(tcp_pkg::OFS_CTRL, 32'h0);
        wr(tcp_pkg::OFS_DEADBAND, 32'h0);
        wr(tcp_pkg::OFS_PERIOD, {16'h0, per});
        wr(tcp_pkg::OFS_CTRL, 32'h5);
        idle(3);
        rd("count", tcp_pkg::OFS_COUNT, {16'h0, per});
        idle(1);
        u_tcp_route_model.hold(n);
        idle(3);
        per = per - 16'(n);
        rd("count", tcp_pkg::OFS_COUNT, {16'h0, per});
        wr(tcp_pkg::OFS_COMPARE, {16'h0, per});
        for (int r = 0; r < 8; r++)
        begin
            wr(tcp_pkg::OFS_CTRL, 32'h5 | (r << 3));
            idle(4);
            pins(r inside {1, 2, 3}, 1'b0, 1'b0);
        end
        u_tcp_route_model.pulse(1'b1);
        idle(3);
        rd("capture", tcp_pkg::OFS_CAPTURE, {16'h0, per});
        rd("intstat", tcp_pkg::OFS_INTSTAT, 32'h4, 32'h4);
        idle(1);
        $display("test enable mode done");
        // one shot stops; interrupt masked, unmasked, cleared
        wr(tcp_pkg::OFS_CTRL, 32'h0);
        wr(tcp_pkg::OFS_PERIOD, 32'h3);
        wr(tcp_pkg::OFS_INTSTAT, 32'h7);
        wr(tcp_pkg::OFS_CTRL, 32'h3);
        idle(12);
        pins(1'b1, 1'b0, 1'b0);
        rd("count", tcp_pkg::OFS_COUNT, 32'h3);
        rd("intstat", tcp_pkg::OFS_INTSTAT, 32'h1, 32'h1);
        wr(tcp_pkg::OFS_INTMASK, 32'h1);
        idle(3);
        pins(1'b1, 1'b0, 1'b1);
        wr(tcp_pkg::OFS_INTSTAT, 32'h1);
        idle(12);
        pins(1'b1, 1'b0, 1'b0);
        // free with period three: one tc clock in every four
        wr(tcp_pkg::OFS_CTRL, 32'h1);
        idle(4);
        k = 0;
        repeat (16) @(negedge clock) k += tcOut;
        @(posedge clock);
        check("tc pulses", k, 32'h4);
        $display("test one shot done");
        // count clock taken from a random routed source
        n = $urandom_range(8, 1);
        k = $urandom_range(3, 1);
        wr(tcp_pkg::OFS_CTRL, 32'h0);
        wr(tcp_pkg::OFS_PERIOD, 32'h100);
        wr(tcp_pkg::OFS_CTRL, 32'h1 | (k << tcp_pkg::CTL_CLK));
        idle(4);
        u_tcp_route_model.ticks(k, n);
        idle(4);
        rd("count", tcp_pkg::OFS_COUNT, 32'h100 - n);
        idle(1);
        $display("test clock select done");
        print_verdict();
    end
endmodule
`default_nettype wire
